// [trace_capture_pkg.sv]
package trace_capture_pkg;

   // Register byte addresses on the APB slave.
   localparam logic [7:0] CONTROL_ADDR    = 8'h00;
   localparam logic [7:0] STATE_ADDR      = 8'h04;
   localparam logic [7:0] EVENT_ADDR      = 8'h08;
   localparam logic [7:0] EVENT_MASK_ADDR = 8'h0c;
   localparam logic [7:0] SAMPLE_ADDR     = 8'h10;

   // Control register fields.
   localparam int CTL_ENABLE      = 0;
   localparam int CTL_BOTH_EDGES  = 1;
   localparam int CTL_WIDTH_LO    = 2;
   localparam int CTL_FLUSH       = 4;
   localparam int CTL_SYS_RESET   = 5;
   localparam int CTL_TAP_RESET   = 6;
   localparam int CTL_DEBUG_REQ   = 7;
   localparam int CTL_EXT_TRIGGER = 8;
   localparam int CTL_MATCH_EN    = 9;
   localparam int CTL_MATCH_LO    = 10;
   localparam logic [12:0] CONTROL_RESET = 13'h0000;

   // Packet width selection codes.
   localparam logic [1:0] WIDTH_4  = 2'h0;
   localparam logic [1:0] WIDTH_8  = 2'h1;
   localparam logic [1:0] WIDTH_16 = 2'h2;

   // State register fields.
   localparam int ST_DATA       = 0;
   localparam int ST_FULL       = 1;
   localparam int ST_CAPTURE    = 2;
   localparam int ST_TRIGGERED  = 3;
   localparam int ST_POWER      = 4;
   localparam int ST_BUS        = 5;
   localparam int ST_DEBUG_ACK  = 6;
   localparam int ST_TGT_RESET  = 7;
   localparam int ST_RET_CLOCK  = 8;
   localparam int ST_COUNT_LO   = 16;

   // Event (interrupt) bits.
   localparam int EV_DATA      = 0;
   localparam int EV_FULL      = 1;
   localparam int EV_TRIGGER   = 2;
   localparam int EV_TGT_RESET = 3;
   localparam int EV_DEBUG_ACK = 4;
   localparam int EV_BITS      = 5;
   localparam logic [4:0] EVENT_MASK_RESET = 5'h00;

   // Sample word layout.
   localparam int SMP_STATUS_LO = 16;
   localparam int SMP_SYNC      = 19;
   localparam int SMP_VALID     = 31;

   // Buffer defaults.
   localparam int BUFFER_DEPTH = 16;
   localparam int PACKET_WIDTH = 16;

   typedef enum logic [2:0] {
      CAP_IDLE      = 3'b001,
      CAP_RUN       = 3'b010,
      CAP_TRIGGERED = 3'b100
   } capture_state_t;

endpackage

// [input_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module input_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta;

   // Two flops per bit; the first stage is read only by the second.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta     <= '0;
         sync_out <= '0;
      end else if (ce) begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule
`default_nettype wire

// [trace_port_capture_unit.sv]
// Function
// - The packet bus is captured at a width of 4, 8 or 16 bits chosen by software.
// - In single-edge mode pipeline status, branch sync and active packet bits are sampled on each rising trace clock edge.
// - In both-edge mode a sample is taken on every rising and every falling trace clock edge.
// - The data-present indicator is high while the buffer holds at least one sample.
// - The buffer-full indicator is high while the buffer has no free entry.
// - The capture-active indicator is high while the buffer is enabled to accept samples.
// - The trigger indicator is high once the trigger condition has occurred in a capture session.
// - The power indicator is on always on own supply, otherwise only while the host initialises.
// - The bus indicator turns on when host initialisation starts and stays on while the expansion bus is powered.
// - The tap reset is an active-low output left released, to its pull-up, when not asserted.
// - An optional external trigger line runs to the target's trace logic and can trigger the session.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module trace_port_capture_unit
   import trace_capture_pkg::*;
#(
   parameter int DEPTH = trace_capture_pkg::BUFFER_DEPTH
) (
   input  wire logic        SYS_CLK,
   input  wire logic        RESET_N,
   input  wire logic        CLK_EN,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   output logic             IRQ,
   input  wire logic        TRACE_CLOCK,
   input  wire logic [2:0]  PIPELINE_STATUS,
   input  wire logic        BRANCH_SYNC,
   input  wire logic [15:0] TRACE_PACKET,
   input  wire logic        OWN_SUPPLY,
   input  wire logic        HOST_INITIALISING,
   input  wire logic        EXPANSION_BUS_POWERED,
   input  wire logic        SYSTEM_RESET_N_IN,
   output logic             SYSTEM_RESET_N_OUT,
   output logic             SYSTEM_RESET_N_OE,
   output logic             TAP_RESET_N_OUT,
   output logic             TAP_RESET_N_OE,
   input  wire logic        DEBUG_ACK,
   output logic             DEBUG_REQUEST,
   output logic             EXTERNAL_TRIGGER,
   input  wire logic        RETURNED_TEST_CLOCK,
   output logic             POWER_INDICATOR,
   output logic             BUS_INDICATOR,
   output logic             DATA_INDICATOR,
   output logic             FULL_INDICATOR,
   output logic             CAPTURE_INDICATOR,
   output logic             TRIGGER_INDICATOR
);

   localparam int PTR_W   = $clog2(DEPTH);
   localparam int CNT_W   = PTR_W + 1;
   localparam int SMP_W   = 20;
   localparam int PIN_W   = 27;

   // Every off-domain pin goes through one shared two-flop synchroniser.
   logic [PIN_W-1:0] pins_raw;
   logic [PIN_W-1:0] pins_sync;
   assign pins_raw = {RETURNED_TEST_CLOCK, DEBUG_ACK, SYSTEM_RESET_N_IN,
                      EXPANSION_BUS_POWERED, HOST_INITIALISING, OWN_SUPPLY,
                      TRACE_CLOCK, BRANCH_SYNC, PIPELINE_STATUS, TRACE_PACKET};

   input_sync #(.WIDTH(PIN_W)) u_sync (
      .clk      (SYS_CLK),
      .reset_n  (RESET_N),
      .ce       (CLK_EN),
      .async_in (pins_raw),
      .sync_out (pins_sync)
   );

   wire [15:0] packet_s    = pins_sync[15:0];
   wire [2:0]  pstat_s     = pins_sync[18:16];
   wire        bsync_s     = pins_sync[19];
   wire        tclk_s      = pins_sync[20];
   wire        own_s       = pins_sync[21];
   wire        init_s      = pins_sync[22];
   wire        buspwr_s    = pins_sync[23];
   wire        sreset_n_s  = pins_sync[24];
   wire        debug_ack_s    = pins_sync[25];
   wire        returned_test_clock_s      = pins_sync[26];

   // Registers and state.
   logic [12:0]          control;
   logic [EV_BITS-1:0]   event_flags;
   logic [EV_BITS-1:0]   event_mask;
   logic [SMP_W-1:0]     buffer [DEPTH];
   logic [PTR_W-1:0]     wr_ptr;
   logic [PTR_W-1:0]     rd_ptr;
   logic [CNT_W-1:0]     count;
   logic                 tclk_prev;
   logic                 init_prev;
   logic                 sreset_prev;
   logic                 debug_ack_prev;
   logic                 bus_on;
   capture_state_t       cap_state;
   capture_state_t       next_cap_state;

   // Packet lane mask from the width code; unknown codes fall back to full width.
   function automatic logic [15:0] lane_mask(input logic [1:0] code);
      logic [15:0] m;
      m = 16'hffff;
      if (code == WIDTH_4) begin
         m = 16'h000f;
      end else if (code == WIDTH_8) begin
         m = 16'h00ff;
      end
      return m;
   endfunction

   // APB decode; pready follows the clock enable so a frozen block stalls the master.
   wire        access     = PSEL && PENABLE && CLK_EN;
   wire        hit_ctl    = (PADDR == CONTROL_ADDR);
   wire        hit_state  = (PADDR == STATE_ADDR);
   wire        hit_event  = (PADDR == EVENT_ADDR);
   wire        hit_mask   = (PADDR == EVENT_MASK_ADDR);
   wire        hit_sample = (PADDR == SAMPLE_ADDR);
   wire        mapped     = hit_ctl || hit_state || hit_event || hit_mask || hit_sample;
   wire        wr_ctl     = access && PWRITE && hit_ctl;
   wire        wr_mask    = access && PWRITE && hit_mask;
   wire        rd_event   = access && !PWRITE && hit_event;
   wire        rd_sample  = access && !PWRITE && hit_sample;

   // Control fields.
   wire        enable     = control[CTL_ENABLE];
   wire        both_edges = control[CTL_BOTH_EDGES];
   wire [1:0]  width_code = control[CTL_WIDTH_LO +: 2];
   wire        match_en   = control[CTL_MATCH_EN];
   wire [2:0]  match_code = control[CTL_MATCH_LO +: 3];
   wire        flush      = wr_ctl && PWDATA[CTL_FLUSH];
   wire        starting   = wr_ctl && PWDATA[CTL_ENABLE] && !enable;

   // Edge detection on the sampled trace clock.
   wire        rise       = tclk_s && !tclk_prev;
   wire        fall       = !tclk_s && tclk_prev;
   wire        take_edge  = rise || (both_edges && fall);

   // Buffer flags.
   wire        is_empty   = (count == '0);
   wire        is_full    = (count == CNT_W'(DEPTH));
   wire        capturing  = enable && (cap_state != CAP_IDLE);
   wire        push       = capturing && take_edge && !is_full && !flush;
   wire        pop        = rd_sample && !is_empty && !flush;
   wire [15:0] packet_m   = packet_s & lane_mask(width_code);

   // Trigger: software-held level on the external trigger line or a status code match.
   wire        ext_trigger_indicator   = EXTERNAL_TRIGGER;
   wire        match_hit  = match_en && take_edge && (pstat_s == match_code);
   wire        trigger_indicator_cond  = capturing && (ext_trigger_indicator || match_hit);

   // Events raised this cycle.
   wire [EV_BITS-1:0] ev_set;
   assign ev_set[EV_DATA]      = push && is_empty;
   assign ev_set[EV_FULL]      = push && (count == CNT_W'(DEPTH - 1));
   assign ev_set[EV_TRIGGER]   = trigger_indicator_cond && (cap_state == CAP_RUN);
   assign ev_set[EV_TGT_RESET] = sreset_prev && !sreset_n_s && !control[CTL_SYS_RESET];
   assign ev_set[EV_DEBUG_ACK] = debug_ack_s && !debug_ack_prev;

   // Capture session: idle until enabled, run until triggered, flush restarts it.
   always_comb begin
      next_cap_state = cap_state;
      unique case (cap_state)
         CAP_IDLE: begin
            if (starting) begin
               next_cap_state = CAP_RUN;
            end
         end
         CAP_RUN: begin
            if (wr_ctl && !PWDATA[CTL_ENABLE]) begin
               next_cap_state = CAP_IDLE;
            end else if (trigger_indicator_cond) begin
               next_cap_state = CAP_TRIGGERED;
            end
         end
         CAP_TRIGGERED: begin
            if (starting || flush) begin
               next_cap_state = CAP_RUN;
            end else if (wr_ctl && !PWDATA[CTL_ENABLE]) begin
               next_cap_state = CAP_IDLE;
            end
         end
         default: begin
            next_cap_state = CAP_IDLE;
         end
      endcase
   end

   // Control register; the flush bit acts as a pulse and is never stored.
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         control <= CONTROL_RESET;
      end else if (CLK_EN && wr_ctl) begin
         control <= PWDATA[12:0] & ~(13'h0001 << CTL_FLUSH);
      end
   end

   // Mask register.
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         event_mask <= EVENT_MASK_RESET;
      end else if (CLK_EN && wr_mask) begin
         event_mask <= PWDATA[EV_BITS-1:0];
      end
   end

   // Sticky events cleared by a read; a new event in the read cycle survives.
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         event_flags <= '0;
      end else if (CLK_EN) begin
         event_flags <= (rd_event ? '0 : event_flags) | ev_set;
      end
   end

   // Buffer storage, written only on a push, at the write pointer.
   always_ff @(posedge SYS_CLK) begin
      if (CLK_EN && push) begin
         buffer[wr_ptr] <= {bsync_s, pstat_s, packet_m};
      end
   end

   // Pointers and fill count; a flush empties the buffer outright.
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else if (CLK_EN) begin
         if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
         end else begin
            if (push) begin
               wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
               rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + CNT_W'(push) - CNT_W'(pop);
         end
      end
   end

   // Edge history of synchronised pins and the capture state.
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         tclk_prev   <= 1'b0;
         init_prev   <= 1'b0;
         sreset_prev <= 1'b0;                                         // Synchroniser resets low.
         debug_ack_prev <= 1'b0;
         cap_state   <= CAP_IDLE;
      end else if (CLK_EN) begin
         tclk_prev   <= tclk_s;
         init_prev   <= init_s;
         sreset_prev <= sreset_n_s;
         debug_ack_prev <= debug_ack_s;
         cap_state   <= next_cap_state;
      end
   end

   // Bus indicator latches on at the start of initialisation, drops with bus power.
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         bus_on <= 1'b0;
      end else if (CLK_EN) begin
         if (!buspwr_s) begin
            bus_on <= 1'b0;
         end else if (init_s && !init_prev) begin
            bus_on <= 1'b1;
         end
      end
   end

   // Indicators and pin drivers, all taken from flops.
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         POWER_INDICATOR   <= 1'b0;
         DATA_INDICATOR    <= 1'b0;
         FULL_INDICATOR    <= 1'b0;
         CAPTURE_INDICATOR <= 1'b0;
         TRIGGER_INDICATOR <= 1'b0;
         IRQ               <= 1'b0;
      end else if (CLK_EN) begin
         POWER_INDICATOR   <= own_s || init_s;
         DATA_INDICATOR    <= !is_empty;
         FULL_INDICATOR    <= is_full;
         CAPTURE_INDICATOR <= capturing;
         TRIGGER_INDICATOR <= (cap_state == CAP_TRIGGERED);
         IRQ               <= |(event_flags & event_mask);
      end
   end

   assign BUS_INDICATOR = bus_on;

   // Open-drain style resets: pull low while asserted, otherwise let go.
   assign SYSTEM_RESET_N_OUT = 1'b0;
   assign SYSTEM_RESET_N_OE  = control[CTL_SYS_RESET];
   assign TAP_RESET_N_OUT    = 1'b0;
   assign TAP_RESET_N_OE     = control[CTL_TAP_RESET];
   assign DEBUG_REQUEST      = control[CTL_DEBUG_REQ];
   assign EXTERNAL_TRIGGER   = control[CTL_EXT_TRIGGER];

   // Read data views.
   wire [31:0] state_word;
   assign state_word = {{(16 - CNT_W){1'b0}}, count, 7'h00, returned_test_clock_s,
                        !sreset_n_s, debug_ack_s, bus_on, own_s || init_s,
                        cap_state == CAP_TRIGGERED, capturing, is_full, !is_empty};

   wire [31:0] sample_word;
   assign sample_word = is_empty ? 32'h0000_0000
                                 : {1'b1, 11'h000, buffer[rd_ptr]};

   wire [31:0] read_mux;
   assign read_mux = hit_ctl    ? {19'h00000, control} :
                     hit_state  ? state_word :
                     hit_event  ? {27'h0000000, event_flags} :
                     hit_mask   ? {27'h0000000, event_mask} :
                     hit_sample ? sample_word : 32'h0000_0000;

   // Zero-wait answer; unmapped addresses read zero and report an error.
   assign PREADY  = CLK_EN;
   assign PRDATA  = (PSEL && PENABLE && !PWRITE) ? read_mux : 32'h0000_0000;
   assign PSLVERR = PSEL && PENABLE && !mapped;

endmodule
`default_nettype wire

// [trace_capture_props.sv]
`timescale 1ns/10ps
`default_nettype none
module trace_capture_props
   import trace_capture_pkg::*;
(
   input wire logic       SYS_CLK,
   input wire logic       RESET_N,
   input wire logic       CLK_EN,
   input wire logic       PSEL,
   input wire logic       PENABLE,
   input wire logic       PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic       PREADY,
   input wire logic       OWN_SUPPLY,
   input wire logic       HOST_INITIALISING,
   input wire logic       EXPANSION_BUS_POWERED,
   input wire logic       SYSTEM_RESET_N_OUT,
   input wire logic       SYSTEM_RESET_N_OE,
   input wire logic       TAP_RESET_N_OUT,
   input wire logic       TAP_RESET_N_OE,
   input wire logic       POWER_INDICATOR,
   input wire logic       BUS_INDICATOR,
   input wire logic       DATA_INDICATOR,
   input wire logic       FULL_INDICATOR,
   input wire logic       TRIGGER_INDICATOR
);
   // A pop or a control write is the only way the buffer may lose its contents.
   wire drain = PSEL && PENABLE && PREADY
                && (PWRITE ? PADDR == CONTROL_ADDR : PADDR == SAMPLE_ADDR);

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);

   // The synchronised levels are allowed three cycles, so six give margin.
   a_ready_enable: assert property (PREADY == CLK_EN)
      else $error("ready does not follow the clock enable");
   a_full_has_data: assert property (FULL_INDICATOR |-> DATA_INDICATOR)
      else $error("full shown while no data shown");
   a_data_drop: assert property ($fell(DATA_INDICATOR) |-> $past(drain) || $past(drain, 2))
      else $error("data indicator fell without a drain");
   a_sysrst_drive: assert property (SYSTEM_RESET_N_OE |-> !SYSTEM_RESET_N_OUT)
      else $error("system reset driven high");
   a_tap_drive: assert property (TAP_RESET_N_OE |-> !TAP_RESET_N_OUT)
      else $error("tap reset driven high");
   a_power_own: assert property (OWN_SUPPLY [*6] |=> POWER_INDICATOR)
      else $error("power off on own supply");
   a_power_off: assert property ((!OWN_SUPPLY && !HOST_INITIALISING) [*6] |=> !POWER_INDICATOR)
      else $error("power on without supply or initialisation");
   a_bus_unpowered: assert property (!EXPANSION_BUS_POWERED [*6] |=> !BUS_INDICATOR)
      else $error("bus indicator on without bus power");

   c_full: cover property (FULL_INDICATOR);
   c_trigger: cover property (TRIGGER_INDICATOR);
   c_drain: cover property (drain && DATA_INDICATOR);
endmodule
`default_nettype wire

// [trace_source.sv]
`timescale 1ns/10ps
`default_nettype none
module trace_source #(
   parameter logic [15:0] PKT_BASE = 16'h1234
) (
   input  wire logic        go,
   input  wire logic        both_edges,
   input  wire logic [3:0]  beats,
   input  wire logic        debug_request,
   output logic             done,
   output logic             trace_clock,
   output logic [2:0]       pipeline_status,
   output logic             branch_sync,
   output logic [15:0]      trace_packet,
   output logic             debug_ack,
   output logic             returned_test_clock
);
   // The target enters debug state on request and hands its test clock back.
   assign debug_ack = debug_request;
   assign returned_test_clock = trace_clock;

   // The trace clock stands still between frames.
   initial begin
      done = 1'h0;
      trace_clock = 1'h0;
      {branch_sync, pipeline_status, trace_packet} = 20'hfffff;
   end

   // Data leads each sampling edge and is held well past it, as a slow target would.
   always @(posedge go) begin : frame
      int i;
      #1;
      done = 1'h0;
      for (i = 0; i < beats; i++) begin
         branch_sync = (i == 0);
         pipeline_status = i[2:0];
         trace_packet = PKT_BASE + i[15:0];
         if (both_edges) begin
            #40;
            trace_clock = ~trace_clock;
            #60;
         end else begin
            #100;
            trace_clock = 1'h1;
            #100;
            trace_clock = 1'h0;
         end
      end
      // Released lines invert, so a late sample cannot match a stale value.
      #100;
      {branch_sync, pipeline_status, trace_packet} = ~{branch_sync, pipeline_status, trace_packet};
      done = 1'h1;
   end
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import trace_capture_pkg::*;
   localparam int          DEPTH_T = 4;
   localparam logic [15:0] PKT_BASE = 16'hc3a5;
   logic        clk, rst_n, psel, penable, pwrite, own, host, busp, tgt_n, go, both, done, err;
   logic        pready, pslverr, irq, tclk, sync, srst_n, srst_oe, trst_n, trst_oe, ce;
   logic        ack, dreq, xtrig, rclk, pwr_i, bus_i, data_i, full_i, cap_i, trigger_indicator_i;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [3:0]  beats;
   logic [2:0]  pstat;
   logic [15:0] pkt;
   wire         srst_line_n;
   int          mismatches = 0;
   int          num_checks = 0;
   int          cycles = 0;

   // The line is low while we drive it or the target pulls it, else pulled up.
   assign srst_line_n = srst_oe ? srst_n : tgt_n;

   trace_port_capture_unit #(.DEPTH(DEPTH_T)) dut (
      .SYS_CLK(clk), .RESET_N(rst_n), .CLK_EN(ce), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .IRQ(irq), .TRACE_CLOCK(tclk), .PIPELINE_STATUS(pstat),
      .BRANCH_SYNC(sync), .TRACE_PACKET(pkt), .OWN_SUPPLY(own), .HOST_INITIALISING(host),
      .EXPANSION_BUS_POWERED(busp), .SYSTEM_RESET_N_IN(srst_line_n),
      .SYSTEM_RESET_N_OUT(srst_n), .SYSTEM_RESET_N_OE(srst_oe), .TAP_RESET_N_OUT(trst_n),
      .TAP_RESET_N_OE(trst_oe), .DEBUG_ACK(ack), .DEBUG_REQUEST(dreq),
      .EXTERNAL_TRIGGER(xtrig), .RETURNED_TEST_CLOCK(rclk), .POWER_INDICATOR(pwr_i),
      .BUS_INDICATOR(bus_i), .DATA_INDICATOR(data_i), .FULL_INDICATOR(full_i),
      .CAPTURE_INDICATOR(cap_i), .TRIGGER_INDICATOR(trigger_indicator_i));

   trace_source #(.PKT_BASE(PKT_BASE)) src (
      .go(go), .both_edges(both), .beats(beats), .debug_request(dreq), .done(done),
      .trace_clock(tclk), .pipeline_status(pstat), .branch_sync(sync), .trace_packet(pkt),
      .debug_ack(ack), .returned_test_clock(rclk));

   // System clock at 40 MHz.
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end

   // The scenarios need well under a thousand cycles; a hang is cut off far beyond that.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         complete_run;
      end
   end

   task automatic complete_run;
      if (mismatches == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // The answer is taken at the edge where pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1) @(posedge clk);
      rdata = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic send(input logic [3:0] n, input logic b);
      int k;
      @(posedge clk);
      beats <= n;
      both <= b;
      go <= 1'h1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (done !== 1'h1 && k < 400);
      go <= 1'h0;
      settle(6);
   endtask

   function automatic logic [31:0] smp(input logic [1:0] wc, input int i);
      logic [15:0] m;
      m = (wc == WIDTH_4) ? 16'h000f : ((wc == WIDTH_8) ? 16'h00ff : 16'hffff);
      return {1'h1, 11'h000, (i == 0), i[2:0], (PKT_BASE + i[15:0]) & m};
   endfunction

   // The control reset value, a field readback and an unmapped access.
   task automatic t_regs;
      apb(1'h0, CONTROL_ADDR, 32'h0);
      check(rdata, 32'h0);
      apb(1'h1, CONTROL_ADDR, 32'hffffe01c);
      apb(1'h0, CONTROL_ADDR, 32'h0);
      check(rdata, 32'h0000000c);
      apb(1'h1, CONTROL_ADDR, 32'h0);
      apb(1'h1, EVENT_MASK_ADDR, 32'hffffffff);
      apb(1'h0, EVENT_MASK_ADDR, 32'h0);
      check(rdata, 32'h0000001f);
      apb(1'h1, EVENT_MASK_ADDR, 32'h0);
      apb(1'h0, 8'h14, 32'h0);
      check({rdata[30:0], err}, 32'h1);
   endtask

   // Capture a frame, drain it in order, and see an overflow dropped rather than kept.
   task automatic t_capture(input logic [1:0] wc, input logic b, input int n);
      int i;
      apb(1'h1, CONTROL_ADDR, 32'h11 | (32'(b) << CTL_BOTH_EDGES) | (32'(wc) << CTL_WIDTH_LO));
      send(n[3:0], b);
      check(data_i, 1'h1);
      check(full_i, n >= DEPTH_T);
      check(irq, 1'h0);
      for (i = 0; i < n && i < DEPTH_T; i++) begin
         apb(1'h0, SAMPLE_ADDR, 32'h0);
         if (b)
            check(rdata, smp(wc, i));
         else
            check(rdata, smp(wc, i));
      end
      apb(1'h0, SAMPLE_ADDR, 32'h0);
      check(rdata, 32'h0);
      settle(2);
      check({data_i, full_i}, 2'h0);
      apb(1'h1, CONTROL_ADDR, 32'h0);
   endtask

   // External and status-match triggers; only the unmasked trigger event interrupts.
   task automatic t_trigger;
      apb(1'h0, EVENT_ADDR, 32'h0);
      apb(1'h1, EVENT_MASK_ADDR, 32'h1 << EV_TRIGGER);
      apb(1'h1, CONTROL_ADDR, 32'h1);
      settle(3);
      check({cap_i, trigger_indicator_i}, 2'h2);
      apb(1'h1, CONTROL_ADDR, 32'h101);
      settle(3);
      check({xtrig, trigger_indicator_i}, 2'h3);
      check(irq, 1'h1);
      apb(1'h0, EVENT_ADDR, 32'h0);
      check(rdata[EV_TRIGGER], 1'h1);
      settle(3);
      check(irq, 1'h0);
      apb(1'h1, CONTROL_ADDR, 32'h0);
      settle(3);
      check(cap_i, 1'h0);
      apb(1'h1, CONTROL_ADDR, 32'h11 | (32'h1 << CTL_MATCH_EN) | (32'h3 << CTL_MATCH_LO));
      settle(3);
      check(trigger_indicator_i, 1'h0);
      send(4'h4, 1'h0);
      check(trigger_indicator_i, 1'h1);
      apb(1'h1, CONTROL_ADDR, 32'h10);
      settle(3);
      check({data_i, full_i}, 2'h0);
      apb(1'h1, EVENT_MASK_ADDR, 32'h0);
   endtask

   // Our reset drives, debug handshake, and a reset started by the target.
   task automatic t_lines;
      apb(1'h0, EVENT_ADDR, 32'h0);
      apb(1'h1, CONTROL_ADDR, 32'he0);
      settle(4);
      check({srst_line_n, trst_oe, trst_n, dreq}, 4'h5);
      apb(1'h0, STATE_ADDR, 32'h0);
      check(rdata[ST_DEBUG_ACK], 1'h1);
      apb(1'h0, EVENT_ADDR, 32'h0);
      check(rdata[EV_TGT_RESET], 1'h0);
      apb(1'h1, CONTROL_ADDR, 32'h0);
      settle(4);
      check({srst_line_n, trst_oe}, 2'h2);
      @(posedge clk);
      tgt_n <= 1'h0;
      settle(5);
      apb(1'h0, EVENT_ADDR, 32'h0);
      check(rdata[EV_TGT_RESET], 1'h1);
      @(posedge clk);
      tgt_n <= 1'h1;
   endtask

   // Own supply, then host initialisation, then bus power removed.
   task automatic t_power;
      @(posedge clk);
      own <= 1'h1;
      busp <= 1'h1;
      settle(5);
      check({pwr_i, bus_i}, 2'h2);
      @(posedge clk);
      own <= 1'h0;
      host <= 1'h1;
      settle(5);
      check({pwr_i, bus_i}, 2'h3);
      @(posedge clk);
      host <= 1'h0;
      settle(5);
      check({pwr_i, bus_i}, 2'h1);
      @(posedge clk);
      busp <= 1'h0;
      ce <= 1'h0;
      settle(1);
      check(pready, 1'h0);
      @(posedge clk);
      ce <= 1'h1;
      settle(5);
      check(bus_i, 1'h0);
   endtask

   initial begin
      {rst_n, psel, penable, pwrite, own, host, busp, go, both} = 9'h000;
      tgt_n = 1'h1;
      ce = 1'h1;
      paddr = 8'h00;
      pwdata = 32'h0;
      beats = 4'h0;
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      t_regs;
      t_capture(WIDTH_4, 1'h0, 3);
      t_capture(WIDTH_8, 1'h1, 4);
      t_capture(WIDTH_16, 1'h0, 6);
      t_capture(2'h3, 1'h1, 2);
      t_trigger;
      t_lines;
      t_power;
      complete_run;
   end
endmodule

bind trace_port_capture_unit trace_capture_props props (
   .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .OWN_SUPPLY(OWN_SUPPLY),
   .HOST_INITIALISING(HOST_INITIALISING), .EXPANSION_BUS_POWERED(EXPANSION_BUS_POWERED),
   .SYSTEM_RESET_N_OUT(SYSTEM_RESET_N_OUT), .SYSTEM_RESET_N_OE(SYSTEM_RESET_N_OE),
   .TAP_RESET_N_OUT(TAP_RESET_N_OUT), .TAP_RESET_N_OE(TAP_RESET_N_OE),
   .POWER_INDICATOR(POWER_INDICATOR), .BUS_INDICATOR(BUS_INDICATOR),
   .DATA_INDICATOR(DATA_INDICATOR), .FULL_INDICATOR(FULL_INDICATOR),
   .TRIGGER_INDICATOR(TRIGGER_INDICATOR));
`default_nettype wire
